// ### aps_defs.svh
// Constants of the auto parameter set sequencer
// How it works
// - While running, step through stored sets in ascending index order on triggers.
// - Each set is applied to exactly its use count of consecutive triggered frames.
// - On a trigger, reuse the set while uses remain, otherwise advance.
// - After the highest set finishes its count, the next trigger restarts at set 0.
// - The cycle holds sets zero to total minus one; total is at most 64.
// - Switching on copies set 0 into the active parameter set at once.
// - The first trigger after switch-on uses set 0 as its first use.
// - Switched off mid-frame: finish that frame, then stop cycling.
// - After switch-off, active values return to those held before switch-on.
// - Set selection indices 0 to 63 choose the store target.
// - Per-set use count accepted from 1 to 256 inclusive.
// - Store copies active values and use count into the selected set, overwriting.
// - A never-stored set within the total acts as default values.
// - Current set changes only with frame triggers, besides explicit commands.
// - Stored sets are volatile and are lost at reset.
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH

`define APS_PARAM_W       32
`define APS_IDX_W         6
`define APS_NSETS         64
`define APS_TOT_W         7
`define APS_CNT_W         9
`define APS_CM1_W         8
`define APS_MODE_W        2
`define APS_MODE_AUTO     2'h0
`define APS_TOTAL_MAX     7'h40
`define APS_TOTAL_MIN     7'h01
`define APS_TOT_ONE       7'h01
`define APS_USE_MAX       9'h100
`define APS_USE_MIN       9'h001
`define APS_USE_ONE       9'h001
`define APS_USE_ZERO      9'h000
`define APS_IDX_ZERO      6'h00
`define APS_IDX_ONE       6'h01
`define APS_DEF_PARAMS    32'h0000_0000
`define APS_DEF_CM1       8'h00

`endif

// ### aps_frame_src.sv
// Frame start trigger source facing the sequencer
`timescale 1ns/1ns
module aps_frame_src (
	input  wire logic clk_i,
	output logic      frame_start_o,
	output logic      frame_busy_o
);
	initial begin
		frame_start_o = 1'b0;
		frame_busy_o  = 1'b0;
	end

	// One trigger pulse, then exposure and readout for busy_n more cycles
	task automatic frame(input int busy_n);
		@(posedge clk_i);
		frame_start_o <= 1'b1;
		frame_busy_o  <= 1'b1;
		@(posedge clk_i);
		frame_start_o <= 1'b0;
		repeat (busy_n) @(posedge clk_i);
		frame_busy_o <= 1'b0;
	endtask : frame
endmodule : aps_frame_src

// ### aps_pkg.sv
// Types of the auto parameter set sequencer
`include "aps_defs.svh"
package aps_pkg;

	typedef struct packed {
		logic [`APS_CM1_W-1:0]   count_m1;
		logic [`APS_PARAM_W-1:0] params;
	} aps_set_t;

	typedef enum logic [2:0] {
		APS_IDLE  = 3'b001,
		APS_RUN   = 3'b010,
		APS_DRAIN = 3'b100
	} aps_state_t;

endpackage : aps_pkg

// ### aps_sequencer.sv
// Auto advance sequencer for stored parameter sets
`timescale 1ns/1ns
`include "aps_defs.svh"
module aps_sequencer (
	input  wire logic                    CORE_CLK_I,
	input  wire logic                    RST_B_I,
	input  wire logic                    SEQUENCER_ON_I,
	input  wire logic [`APS_MODE_W-1:0]  ADVANCE_MODE_SELECT_I,
	input  wire logic [`APS_TOT_W-1:0]   CYCLE_SET_TOTAL_I,
	input  wire logic [`APS_IDX_W-1:0]   SET_SELECT_INDEX_I,
	input  wire logic [`APS_CNT_W-1:0]   SET_USE_COUNT_I,
	input  wire logic                    STORE_ACTIVE_TO_SET_CMD_I,
	input  wire logic [`APS_PARAM_W-1:0] ACTIVE_PARAMS_I,
	input  wire logic                    FRAME_START_I,
	input  wire logic                    FRAME_BUSY_I,
	output logic      [`APS_PARAM_W-1:0] ACTIVE_PARAMS_O,
	output logic      [`APS_IDX_W-1:0]   CURRENT_SET_O,
	output logic      [`APS_CNT_W-1:0]   USES_DONE_O,
	output logic                         RUNNING_O
);

	logic                    rst_meta_q;
	logic                    rst_n_q;
	aps_pkg::aps_state_t     state_q;
	logic                    running_q;
	logic [`APS_IDX_W-1:0]   cur_q;
	logic [`APS_CNT_W-1:0]   uses_q;
	logic [`APS_TOT_W-1:0]   total_q;
	logic [`APS_PARAM_W-1:0] active_q;
	logic [`APS_PARAM_W-1:0] saved_q;
	aps_pkg::aps_set_t       wr_data;
	aps_pkg::aps_set_t       cur_set;
	aps_pkg::aps_set_t       load_set;
	logic [`APS_IDX_W-1:0]   nxt_idx;
	logic [`APS_IDX_W-1:0]   load_idx;
	logic [`APS_CNT_W-1:0]   cur_count;
	logic                    start;
	logic                    trig;
	logic                    reuse;
	logic                    advance;
	logic                    stop_now;
	logic                    to_drain;
	logic                    finish;

	// Clamp the use count into 1..256 and encode it as count minus one
	function automatic logic [`APS_CM1_W-1:0] enc_count(input logic [`APS_CNT_W-1:0] c);
		logic [`APS_CNT_W-1:0] k;
		k = c;
		if (k < `APS_USE_MIN) begin
			k = `APS_USE_MIN;
		end else if (k > `APS_USE_MAX) begin
			k = `APS_USE_MAX;
		end
		return k[`APS_CM1_W-1:0] - `APS_DEF_CM1 - 8'h01;
	endfunction : enc_count

	function automatic logic [`APS_CNT_W-1:0] dec_count(input logic [`APS_CM1_W-1:0] m);
		return {1'b0, m} + `APS_USE_ONE;
	endfunction : dec_count

	// Clamp the cycle total into 1..64
	function automatic logic [`APS_TOT_W-1:0] clamp_total(input logic [`APS_TOT_W-1:0] t);
		logic [`APS_TOT_W-1:0] k;
		k = t;
		if (k < `APS_TOTAL_MIN) begin
			k = `APS_TOTAL_MIN;
		end else if (k > `APS_TOTAL_MAX) begin
			k = `APS_TOTAL_MAX;
		end
		return k;
	endfunction : clamp_total

	// Reset release through two flip-flops
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Store path: index is six bits wide so 0..63 all reach a set
	always_comb begin
		wr_data.count_m1 = enc_count(SET_USE_COUNT_I);
		wr_data.params   = ACTIVE_PARAMS_I;
	end

	aps_set_mem u_mem (
		.clk_i      (CORE_CLK_I),
		.rst_n_i    (rst_n_q),
		.wr_en_i    (STORE_ACTIVE_TO_SET_CMD_I),
		.wr_idx_i   (SET_SELECT_INDEX_I),
		.wr_data_i  (wr_data),
		.rd_a_idx_i (cur_q),
		.rd_a_o     (cur_set),
		.rd_b_idx_i (load_idx),
		.rd_b_o     (load_set)
	);

	// Sequencing decisions
	always_comb begin
		nxt_idx   = cur_q + `APS_IDX_ONE;
		if ({1'b0, cur_q} + `APS_TOT_ONE >= total_q) begin
			nxt_idx = `APS_IDX_ZERO;
		end
		load_idx  = (state_q == aps_pkg::APS_RUN) ? nxt_idx : `APS_IDX_ZERO;
		cur_count = dec_count(cur_set.count_m1);
		start     = (state_q == aps_pkg::APS_IDLE) && SEQUENCER_ON_I &&
			(ADVANCE_MODE_SELECT_I == `APS_MODE_AUTO);
		stop_now  = (state_q == aps_pkg::APS_RUN) && !SEQUENCER_ON_I;
		to_drain  = stop_now && FRAME_BUSY_I;
		finish    = (stop_now && !FRAME_BUSY_I) ||
			((state_q == aps_pkg::APS_DRAIN) && !FRAME_BUSY_I);
		trig      = (state_q == aps_pkg::APS_RUN) && SEQUENCER_ON_I && FRAME_START_I;
		reuse     = trig && (uses_q < cur_count);
		advance   = trig && !(uses_q < cur_count);
	end

	// Mode state
	always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q   <= aps_pkg::APS_IDLE;
			running_q <= 1'b0;
		end else begin
			unique case (state_q)
				aps_pkg::APS_IDLE: begin
					if (start) begin
						state_q   <= aps_pkg::APS_RUN;
						running_q <= 1'b1;
					end
				end
				aps_pkg::APS_RUN: begin
					if (to_drain) begin
						state_q <= aps_pkg::APS_DRAIN;
					end else if (finish) begin
						state_q   <= aps_pkg::APS_IDLE;
						running_q <= 1'b0;
					end
				end
				aps_pkg::APS_DRAIN: begin
					if (finish) begin
						state_q   <= aps_pkg::APS_IDLE;
						running_q <= 1'b0;
					end
				end
				default: begin
					state_q   <= aps_pkg::APS_IDLE;
					running_q <= 1'b0;
				end
			endcase
		end
	end

	// Cycle total is latched at switch-on
	always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			total_q <= `APS_TOTAL_MIN;
		end else if (start) begin
			total_q <= clamp_total(CYCLE_SET_TOTAL_I);
		end
	end

	// Current set and use counter
	always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cur_q  <= `APS_IDX_ZERO;
			uses_q <= `APS_USE_ZERO;
		end else if (start) begin
			cur_q  <= `APS_IDX_ZERO;
			uses_q <= `APS_USE_ZERO;
		end else if (reuse) begin
			uses_q <= uses_q + `APS_USE_ONE;
		end else if (advance) begin
			cur_q  <= nxt_idx;
			uses_q <= `APS_USE_ONE;
		end
	end

	// Values in force before switch-on are kept for restoring
	always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			saved_q <= `APS_DEF_PARAMS;
		end else if (start) begin
			saved_q <= ACTIVE_PARAMS_I;
		end
	end

	// Active parameter set seen by the acquisition logic
	always_ff @(posedge CORE_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			active_q <= `APS_DEF_PARAMS;
		end else if (start) begin
			active_q <= load_set.params;
		end else if (advance) begin
			active_q <= load_set.params;
		end else if (finish) begin
			active_q <= saved_q;
		end else if (state_q == aps_pkg::APS_IDLE) begin
			active_q <= ACTIVE_PARAMS_I;
		end
	end

	assign ACTIVE_PARAMS_O = active_q;
	assign CURRENT_SET_O   = cur_q;
	assign USES_DONE_O     = uses_q;
	assign RUNNING_O       = running_q;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!rst_n_q);

	sequence s_switch_on;
		(state_q == aps_pkg::APS_IDLE) && SEQUENCER_ON_I &&
			(ADVANCE_MODE_SELECT_I == `APS_MODE_AUTO);
	endsequence

	sequence s_trigger;
		(state_q == aps_pkg::APS_RUN) && SEQUENCER_ON_I && FRAME_START_I;
	endsequence

	sequence s_off_busy;
		(state_q == aps_pkg::APS_RUN) && !SEQUENCER_ON_I && FRAME_BUSY_I;
	endsequence

	load_on_switch_a: assert property (
		s_switch_on |=> (cur_q == `APS_IDX_ZERO) && (uses_q == `APS_USE_ZERO) &&
			(active_q == $past(load_set.params)) && running_q)
		else $error("switch-on did not load set 0");

	first_use_a: assert property (
		s_trigger and (uses_q == `APS_USE_ZERO) |->
			(cur_q == `APS_IDX_ZERO) && (active_q == cur_set.params))
		else $error("first trigger after switch-on did not use set 0");

	first_trig_a: assert property (
		s_trigger and (uses_q == `APS_USE_ZERO) |=>
			(cur_q == $past(cur_q)) && (uses_q == `APS_USE_ONE))
		else $error("first trigger did not count as first use");

	reuse_hold_a: assert property (
		s_trigger and (uses_q < cur_count) |=>
			$stable(cur_q) && (uses_q == $past(uses_q) + `APS_USE_ONE) && $stable(active_q))
		else $error("set not reused while uses remain");

	advance_step_a: assert property (
		s_trigger and (uses_q >= cur_count) |=>
			({1'b0, cur_q} == ({1'b0, $past(cur_q)} + `APS_TOT_ONE) % total_q) &&
			(uses_q == `APS_USE_ONE) && (active_q == cur_set.params))
		else $error("advance did not move to next set");

	wrap_to_zero_a: assert property (
		s_trigger and (uses_q >= cur_count) and ({1'b0, cur_q} == total_q - 7'h01) |=>
			(cur_q == `APS_IDX_ZERO))
		else $error("cycle did not wrap to set 0");

	index_range_a: assert property (
		(state_q != aps_pkg::APS_IDLE) |-> ({1'b0, cur_q} < total_q) &&
			(total_q <= `APS_TOTAL_MAX))
		else $error("current set outside the cycle");

	drain_hold_a: assert property (
		s_off_busy ##1 FRAME_BUSY_I |-> (state_q == aps_pkg::APS_DRAIN) &&
			$stable(cur_q) && $stable(uses_q))
		else $error("cycling did not stop on switch-off");

	restore_values_a: assert property (
		(state_q != aps_pkg::APS_IDLE) ##1 (state_q == aps_pkg::APS_IDLE) |->
			(active_q == saved_q) && !running_q)
		else $error("active values not restored");

	trig_only_a: assert property (
		(state_q == aps_pkg::APS_RUN) && !FRAME_START_I && SEQUENCER_ON_I |=>
			$stable(cur_q) && $stable(uses_q))
		else $error("set changed without a trigger");

	idle_trig_a: assert property (
		(state_q == aps_pkg::APS_IDLE) && !SEQUENCER_ON_I && FRAME_START_I |=>
			$stable(cur_q) && $stable(uses_q))
		else $error("trigger while off changed counters");

	drain_freeze_a: assert property (
		(state_q == aps_pkg::APS_DRAIN) |=>
			$stable(cur_q) && $stable(uses_q))
		else $error("set or count changed while draining");

	drain_end_a: assert property (
		(state_q == aps_pkg::APS_DRAIN) && !FRAME_BUSY_I |=>
			(state_q == aps_pkg::APS_IDLE) && !running_q && (active_q == saved_q))
		else $error("drain did not end after the frame");

	use_bound_a: assert property (
		(state_q != aps_pkg::APS_IDLE) |->
			(uses_q <= cur_count))
		else $error("uses exceed the set count");

	mode_gate_a: assert property (
		(state_q == aps_pkg::APS_IDLE) && SEQUENCER_ON_I &&
			(ADVANCE_MODE_SELECT_I != `APS_MODE_AUTO) |=> (state_q == aps_pkg::APS_IDLE) && !running_q)
		else $error("switch-on taken outside auto mode");

	total_latch_a: assert property (
		(state_q != aps_pkg::APS_IDLE) |=>
			$stable(total_q))
		else $error("cycle total changed while running");

endmodule : aps_sequencer

// ### aps_set_mem.sv
// Stored parameter sets with two read ports and default fill
`timescale 1ns/1ns
`include "aps_defs.svh"
module aps_set_mem (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  wr_en_i,
	input  wire logic [`APS_IDX_W-1:0] wr_idx_i,
	input  wire aps_pkg::aps_set_t     wr_data_i,
	input  wire logic [`APS_IDX_W-1:0] rd_a_idx_i,
	output aps_pkg::aps_set_t          rd_a_o,
	input  wire logic [`APS_IDX_W-1:0] rd_b_idx_i,
	output aps_pkg::aps_set_t          rd_b_o
);

	aps_pkg::aps_set_t        mem [`APS_NSETS];
	logic [`APS_NSETS-1:0]    valid_q;

	function automatic aps_pkg::aps_set_t read_set(input logic [`APS_IDX_W-1:0] idx,
		input logic [`APS_NSETS-1:0] vld, input aps_pkg::aps_set_t word);
		aps_pkg::aps_set_t r;
		r.count_m1 = `APS_DEF_CM1;
		r.params   = `APS_DEF_PARAMS;
		if (vld[idx]) begin
			r = word;
		end
		return r;
	endfunction : read_set

	// Contents are volatile: reset forgets every set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_q <= '0;
		end else if (wr_en_i) begin
			valid_q[wr_idx_i] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
	end

	assign rd_a_o = read_set(rd_a_idx_i, valid_q, mem[rd_a_idx_i]);
	assign rd_b_o = read_set(rd_b_idx_i, valid_q, mem[rd_b_idx_i]);

endmodule : aps_set_mem

// ### tb_top.sv
// Self-checking bench of the auto parameter set sequencer
`timescale 1ns/1ns
`include "aps_defs.svh"
module tb_top;
	logic                    clk   = 1'b0;
	logic                    rst_b = 1'b0;
	logic                    on    = 1'b0;
	logic [`APS_MODE_W-1:0]  mode  = `APS_MODE_AUTO;
	logic [`APS_TOT_W-1:0]   tot   = 7'h01;
	logic [`APS_IDX_W-1:0]   idx   = 6'h00;
	logic [`APS_CNT_W-1:0]   cnt   = 9'h001;
	logic                    st    = 1'b0;
	logic [`APS_PARAM_W-1:0] pin   = 32'h0000_0000;
	logic                    fs;
	logic                    busy;
	logic [`APS_PARAM_W-1:0] par_o;
	logic [`APS_IDX_W-1:0]   cur_o;
	logic [`APS_CNT_W-1:0]   uses_o;
	logic                    run_o;
	logic [31:0]             saved;
	logic [31:0]             epar[64];
	int                      ecnt[64];
	int                      e_tot, e_cur, e_uses;
	int                      err_count = 0;
	int                      checks = 0;
	int                      cyc = 0;

	always #5 clk = ~clk;

	aps_sequencer DUT (.CORE_CLK_I(clk), .RST_B_I(rst_b), .SEQUENCER_ON_I(on),
		.ADVANCE_MODE_SELECT_I(mode), .CYCLE_SET_TOTAL_I(tot), .SET_SELECT_INDEX_I(idx),
		.SET_USE_COUNT_I(cnt), .STORE_ACTIVE_TO_SET_CMD_I(st), .ACTIVE_PARAMS_I(pin),
		.FRAME_START_I(fs), .FRAME_BUSY_I(busy), .ACTIVE_PARAMS_O(par_o),
		.CURRENT_SET_O(cur_o), .USES_DONE_O(uses_o), .RUNNING_O(run_o));

	aps_frame_src src (.clk_i(clk), .frame_start_o(fs), .frame_busy_o(busy));

	task automatic end_sim;
		$display("err_count %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [5:0] c, input logic [8:0] u, input logic [31:0] p,
		input logic r);
		checks++;
		if (cur_o !== c || uses_o !== u || par_o !== p || run_o !== r) begin
			err_count++;
			$display("unexpected t=%0t cur %0d uses %0d par %h run %b", $time, cur_o,
				uses_o, par_o, run_o);
		end
	endtask : chk

	task automatic cmp1(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp1

	function automatic void step();
		if (e_uses < ecnt[e_cur])
			e_uses++;
		else begin
			e_cur  = (e_cur + 1) % e_tot;
			e_uses = 1;
		end
	endfunction : step

	task automatic do_reset;
		rst_b <= 1'b0;
		on    <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ecnt[i]) begin
			ecnt[i] = 1;
			epar[i] = '0;
		end
		@(negedge clk);
		chk(6'h00, 9'h000, pin, 1'b0);
	endtask : do_reset

	task automatic store(input int i, input int c, input logic [31:0] p);
		@(posedge clk);
		idx <= 6'(i);
		cnt <= 9'(c);
		pin <= p;
		st  <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		ecnt[i] = (c == 0) ? 1 : (c > 256) ? 256 : c;
		epar[i] = p;
	endtask : store

	task automatic switch_on(input int t);
		@(posedge clk);
		mode <= `APS_MODE_AUTO;
		tot  <= 7'(t);
		on   <= 1'b1;
		@(posedge clk);
		saved = pin;
		@(negedge clk);
		e_tot  = (t < 1) ? 1 : (t > 64) ? 64 : t;
		e_cur  = 0;
		e_uses = 0;
		chk(6'h00, 9'h000, epar[0], 1'b1);
	endtask : switch_on

	task automatic trigs(input int n);
		repeat (n) begin
			src.frame(0);
			@(negedge clk);
			step();
			chk(6'(e_cur), 9'(e_uses), epar[e_cur], 1'b1);
		end
	endtask : trigs

	task automatic off_wait;
		@(posedge clk);
		on <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(6'(e_cur), 9'(e_uses), saved, 1'b0);
		repeat (2) @(posedge clk);
	endtask : off_wait

	task automatic s_cycle;
		store(0, 0, 32'hA000_0000);
		store(1, 3, 32'hA000_0001);
		store(2, 2, 32'hA000_0002);
		switch_on(3);
		trigs(9);
	endtask : s_cycle

	task automatic s_off;
		int n;
		fork
			src.frame(6);
		join_none
		@(posedge clk);
		@(posedge clk);
		pin <= 32'hC0DE_0001;
		on  <= 1'b0;
		step();
		@(negedge clk);
		chk(6'(e_cur), 9'(e_uses), epar[e_cur], 1'b1);
		repeat (2) @(negedge clk);
		cmp1(32'(run_o), 32'h0000_0001);
		n = 0;
		while (run_o !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		cmp1(32'(busy), 32'h0000_0000);
		cmp1(par_o, saved);
		src.frame(0);
		src.frame(0);
		@(negedge clk);
		chk(6'(e_cur), 9'(e_uses), pin, 1'b0);
		switch_on(3);
		trigs(4);
		off_wait();
	endtask : s_off

	task automatic s_mode;
		for (int m = 1; m < 4; m++) begin
			@(posedge clk);
			mode <= 2'(m);
			on   <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk(6'(e_cur), 9'(e_uses), pin, 1'b0);
			@(posedge clk);
			on <= 1'b0;
		end
	endtask : s_mode

	task automatic s_max;
		store(0, 511, 32'hD000_0000);
		switch_on(1);
		trigs(257);
		off_wait();
	endtask : s_max

	task automatic s_wide;
		do_reset();
		store(63, 1, 32'hBEEF_0063);
		switch_on(127);
		trigs(65);
		off_wait();
	endtask : s_wide

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		do_reset();
		s_cycle();
		s_off();
		s_mode();
		s_max();
		s_wide();
		end_sim();
	end
endmodule : tb_top
